// [dv/dma_partner.sv]
// Purpose: system DMA controller model answering transfer requests
// Assumes: acknowledge strobed per byte, no read or write strobes
// Notes:   slow_i adds wait cycles; tc_req_i ends the transfer
`timescale 1ns/1ns
module dma_partner (
	input  wire logic       clk_i,
	input  wire logic       en_i,
	input  wire logic       drq_i,
	input  wire logic [3:0] slow_i,
	input  wire logic       tc_req_i,
	output logic            dack_n_o,
	output logic            tc_o,
	output logic      [7:0] nbytes_o
);
	int i;
	initial begin
		dack_n_o = 1'b1;
		tc_o = 1'b0;
		nbytes_o = 8'h00;
		forever begin
			@(negedge clk_i);
			if (en_i && drq_i) begin
				for (i = 0; i < slow_i; i++) @(negedge clk_i);
				dack_n_o = 1'b0;
				tc_o = tc_req_i;
				repeat (2) @(negedge clk_i);
				dack_n_o = 1'b1;
				tc_o = 1'b0;
				nbytes_o = nbytes_o + 8'h01;
				@(negedge clk_i);
			end
		end
	end
endmodule

// [dv/tb_top.sv]
// Purpose: self-checking bench for phase sequencing and transfer requests
// Assumes: inputs change at the falling clock edge
// Notes:   expected values queued by the driver, compared by a monitor
`timescale 1ns/1ns
module tb_top;
	logic       clk_i, resetn_i, soft_reset_i, cs_n, rd_n, wr_n, nondma, dma_en;
	logic       fifo_en, burst, dbyte, sec_end, done, pen, tcq, dack_n, tc, drq, irq;
	logic [7:0] wdata, main_status_register, nbytes;
	logic [3:0] thr, slow;
	logic [1:0] mode, phase;
	logic [4:0] cnt;
	logic [2:0] qk[$];
	logic [7:0] qv[$];
	int         miscompares, n_compared, k, m, j, nb;

	floppy_phase_dma_request #(.FIFO_DEPTH(16), .SECTOR_BYTES(512)) dut_u (
		.clk_i(clk_i), .resetn_i(resetn_i), .soft_reset_i(soft_reset_i),
		.host_cs_n_i(cs_n), .host_rd_n_i(rd_n), .host_wr_n_i(wr_n),
		.host_data_sel_i(1'b1), .host_wdata_i(wdata), .dack_n_i(dack_n), .tc_i(tc),
		.nondma_select_i(nondma), .dma_enable_i(dma_en), .mode_select_i(mode),
		.fifo_enable_i(fifo_en), .burst_mode_i(burst), .fifo_trigger_level_i(thr),
		.disk_byte_i(dbyte), .sector_end_i(sec_end), .next_sector_i(1'b0),
		.exec_done_i(done), .main_status_register_o(main_status_register), .drq_o(drq),
		.floppy_interrupt_line_o(irq), .phase_o(phase), .fifo_count_o(cnt));
	dma_partner partner_u (.clk_i(clk_i), .en_i(pen), .drq_i(drq), .slow_i(slow),
		.tc_req_i(tcq), .dack_n_o(dack_n), .tc_o(tc), .nbytes_o(nbytes));

	function automatic logic [7:0] obs(input logic [2:0] c);
		case (c)
			3'h0: return main_status_register;
			3'h1: return {6'h00, phase};
			3'h2: return {7'h00, drq};
			3'h3: return {7'h00, irq};
			3'h4: return {3'h0, cnt};
			3'h6: return {7'h00, dack_n};
			default: return nbytes;
		endcase
	endfunction
	task automatic expect_v(input logic [2:0] c, input logic [7:0] v);
		qk.push_back(c);
		qv.push_back(v);
	endtask
	always begin
		@(negedge clk_i);
		#5;
		while (qk.size() > 0) begin
			n_compared++;
			if (obs(qk[0]) !== qv[0]) begin
				miscompares++;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, obs(qk[0]), qv[0]);
			end
			void'(qk.pop_front());
			void'(qv.pop_front());
		end
	end
	task automatic close_out();
		if (miscompares == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic host_io(input logic w, input logic [7:0] d);
		for (k = 0; k < 50 && !(main_status_register[7] && (main_status_register[6] !== w)); k++) cyc(1);
		cs_n = 1'b0;
		wdata = d;
		wr_n = !w;
		rd_n = w;
		cyc(1);
		wr_n = 1'b1;
		rd_n = 1'b1;
		cs_n = 1'b1;
		cyc(1);
	endtask
	task automatic wait_for(input logic [2:0] c, input logic [7:0] v);
		for (k = 0; k < 300 && obs(c) !== v; k++) cyc(1);
		expect_v(c, v);
	endtask
	task automatic command(input logic [7:0] op, input int np);
		host_io(1'b1, op);
		expect_v(3'h1, (np > 0) ? 8'h01 : 8'h02);
		expect_v(3'h0, (np > 0) ? 8'h90 : 8'h10);
		for (m = 0; m < np; m++) host_io(1'b1, 8'h00);
	endtask
	task automatic results(input int n);
		for (m = 0; m < n; m++) begin
			host_io(1'b0, 8'h00);
			if (m == 0) expect_v(3'h3, 8'h00);
		end
		expect_v(3'h0, 8'h80);
		expect_v(3'h1, 8'h00);
	endtask
	task automatic pulse_byte(input logic s);
		dbyte = !s;
		sec_end = s;
		cyc(1);
		dbyte = 1'b0;
		sec_end = 1'b0;
		cyc(1);
	endtask
	task automatic finish_dma(input int nres);
		tcq = 1'b1;
		pen = 1'b1;
		pulse_byte(1'b0);
		wait_for(3'h1, 8'h03);
		expect_v(3'h3, 8'h01);
		tcq = 1'b0;
		pen = 1'b0;
		wait_for(3'h6, 8'h01);
		results(nres);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial begin
		#400_000;
		miscompares++;
		close_out();
	end
	initial begin
		{soft_reset_i, nondma, fifo_en, burst, dbyte, sec_end, done, pen, tcq} = '0;
		{cs_n, rd_n, wr_n, dma_en} = '1;
		resetn_i = 1'b0;
		wdata = 8'h00;
		mode = 2'h3;
		thr = 4'h0;
		void'($urandom(32'hcc67_ecd9));
		slow = 4'($urandom_range(3, 0));
		cyc(16);
		resetn_i = 1'b1;
		cyc(1);
		expect_v(3'h0, 8'h80);
		expect_v(3'h2, 8'h00);
		command(8'h08, 0);
		done = 1'b1;
		cyc(1);
		done = 1'b0;
		cyc(1);
		expect_v(3'h1, 8'h03);
		expect_v(3'h3, 8'h01);
		expect_v(3'h0, 8'hd0);
		results(2);
		command(8'h0f, 2);
		cyc(1);
		expect_v(3'h0, 8'h80);
		for (j = 0; j < 2; j++) begin
			mode = j ? 2'h1 : 2'h3;
			dma_en = !j;
			command(8'h06, 8);
			expect_v(3'h1, 8'h02);
			nb = nbytes;
			pulse_byte(1'b0);
			wait_for(3'h2, 8'h01);
			pen = 1'b1;
			wait_for(3'h2, 8'h00);
			expect_v(3'h6, 8'h00);
			pulse_byte(1'b0);
			pulse_byte(1'b0);
			wait_for(3'h4, 8'h00);
			cyc(6);
			expect_v(3'h5, 8'(nb + 3));
			finish_dma(7);
		end
		mode = 2'h3;
		dma_en = 1'b1;
		fifo_en = 1'b1;
		for (j = 0; j < 2; j++) begin
			burst = !j;
			thr = 4'($urandom_range(14, 1));
			command(8'h06, 8);
			repeat (15 - thr) pulse_byte(1'b0);
			cyc(2);
			expect_v(3'h2, 8'h00);
			pulse_byte(1'b0);
			cyc(1);
			expect_v(3'h2, 8'h01);
			pen = 1'b1;
			wait_for(3'h4, 8'h00);
			cyc(2);
			expect_v(3'h2, 8'h00);
			pen = 1'b0;
			pulse_byte(1'b0);
			cyc(2);
			expect_v(3'h2, 8'h00);
			pulse_byte(1'b1);
			cyc(1);
			expect_v(3'h2, 8'h01);
			finish_dma(7);
		end
		burst = 1'b1;
		command(8'h05, 8);
		pen = 1'b1;
		wait_for(3'h4, 8'h10);
		cyc(2);
		expect_v(3'h2, 8'h00);
		pen = 1'b0;
		repeat (16) pulse_byte(1'b0);
		finish_dma(7);
		fifo_en = 1'b0;
		nondma = 1'b1;
		command(8'h06, 8);
		pulse_byte(1'b0);
		wait_for(3'h3, 8'h01);
		expect_v(3'h0, 8'hf0);
		host_io(1'b0, 8'h00);
		expect_v(3'h3, 8'h00);
		done = 1'b1;
		wait_for(3'h1, 8'h03);
		done = 1'b0;
		results(7);
		nondma = 1'b0;
		command(8'h06, 8);
		soft_reset_i = 1'b1;
		cyc(1);
		soft_reset_i = 1'b0;
		cyc(1);
		expect_v(3'h0, 8'h80);
		expect_v(3'h1, 8'h00);
		cyc(4);
		close_out();
	end
endmodule

// [verilog/fdc_phase_consts.svh]
//----------------------------------------------------------------------
// Purpose: constants for floppy phase sequencing and transfer requests
// Assumes: one 25 MHz clock, all inputs synchronous
// Notes:   Notes on behaviour listed below
//----------------------------------------------------------------------
// Notes on behaviour
// - idle without a command; command, execution, result phases run in order.
// - first data byte is the opcode; it sets the count of parameter bytes.
// - execution starts right after the final parameter byte is written; commands with no result bytes go back to idle instead.
// - busy flag set on first byte; cleared after last result or command byte.
// - non-DMA modes raise an interrupt for every data byte to move.
// - DMA only with specify non-DMA bit 0 and drive register DMA enable; in the second compat mode the DMA enable is ignored.
// - FIFO off: request when byte ready, cleared on acknowledge falling edge.
// - after the last DMA byte an interrupt marks the result phase start.
// - during DMA acknowledge alone selects the FIFO; address lines ignored.
// - terminal count ends transfer anytime, recognised only with acknowledge low.
// - first compat mode with FIFO off: single bytes, request drops between.
// - second compat mode FIFO off: threshold 0Fh, reassert when acknowledge high.
// - FIFO reads: request while byte count at least 16 minus trigger level.
// - burst reads hold request until FIFO empty, then wait for trigger.
// - non-burst reads drop per transfer, reassert after 350 ns if data.
// - after the last sector byte from disk, request even below threshold.
// - FIFO writes: request while count at most trigger level; burst until full.
// - non-burst writes drop per transfer, reassert after 350 ns if not full.
// - writes count sector bytes; drop after the last, wait for next sector.
// - burst drop at acknowledge edge of last byte, or strobe end within 50 ns.
// - mode bits 11 select first compat mode (default), 01 the second.
// - end-of-execution interrupt clears on the first result byte read.
//----------------------------------------------------------------------
`ifndef FDC_PHASE_CONSTS_SVH
`define FDC_PHASE_CONSTS_SVH

`define MSR_RQM         7
`define MSR_DIO         6
`define MSR_NDMA        5
`define MSR_CIP         4
`define MSR_RESET       8'h80

`define MODE_FIRST      2'h3
`define MODE_SECOND     2'h1
`define THR_FIFO_OFF    4'hf

`define CLK_PERIOD_NS   40
`define GAP_NS          350
`define GAP_CYCLES      ((`GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DROP_NS         50
`define DROP_CYCLES     (`DROP_NS / `CLK_PERIOD_NS)

`define OP_SPECIFY      5'h03
`define OP_WRITE_DATA   5'h05
`define OP_READ_DATA    5'h06
`define OP_RECALIBRATE  5'h07
`define OP_SENSE_INT    5'h08
`define OP_SEEK         5'h0f
`define PAR_DATA        4'h8
`define PAR_SPECIFY     4'h2
`define PAR_RECAL       4'h1
`define PAR_SEEK        4'h2
`define PAR_NONE        4'h0
`define RES_DATA        4'h7
`define RES_SENSE       4'h2
`define RES_INVALID     4'h1
`define RES_NONE        4'h0

`endif

// [verilog/fdc_phase_pkg.sv]
//----------------------------------------------------------------------
// Purpose: shared types for floppy phase sequencing
// Assumes: nothing
// Notes:   constants live in fdc_phase_consts.svh
//----------------------------------------------------------------------
package fdc_phase_pkg;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_COMMAND,
		PH_EXECUTION,
		PH_RESULT
	} phase_t;

	typedef enum logic [1:0] {
		DIR_NONE,
		DIR_READ,
		DIR_WRITE
	} dir_t;

endpackage

// [verilog/fifo_level_counter.sv]
//----------------------------------------------------------------------
// Purpose: byte occupancy count of the data FIFO
// Assumes: push and pop are single-cycle events
// Notes:   saturates at 0 and DEPTH
//----------------------------------------------------------------------
`timescale 1ns/1ns
module fifo_level_counter #(
	parameter int DEPTH = 16,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic          clk_i,
	input  wire logic          resetn_i,
	input  wire logic          clear_i,
	input  wire logic          push_i,
	input  wire logic          pop_i,
	output logic      [CW-1:0] count_o
);

	typedef struct packed {
		logic [CW-1:0] count;
	} cnt_state_t;

	cnt_state_t s;
	cnt_state_t n;

	always_comb begin
		n = s;
		if (clear_i) begin
			n.count = '0;
		end else if (push_i && !pop_i && s.count != CW'(DEPTH)) begin
			n.count = s.count + CW'(1);
		end else if (pop_i && !push_i && s.count != '0) begin
			n.count = s.count - CW'(1);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign count_o = s.count;

endmodule

// [verilog/floppy_phase_dma_request.sv]
//----------------------------------------------------------------------
// Purpose: command/execution/result sequencing and DMA or interrupt requests
// Assumes: host strobes and DMA pins already synchronous to clk_i
// Notes:   FIFO data path lives in the core; only its level is tracked here
//----------------------------------------------------------------------
`timescale 1ns/1ns
`include "fdc_phase_consts.svh"
module floppy_phase_dma_request
	import fdc_phase_pkg::*;
#(
	parameter int FIFO_DEPTH   = 16,
	parameter int SECTOR_BYTES = 512
) (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       soft_reset_i,
	input  wire logic       host_cs_n_i,
	input  wire logic       host_rd_n_i,
	input  wire logic       host_wr_n_i,
	input  wire logic       host_data_sel_i,
	input  wire logic [7:0] host_wdata_i,
	input  wire logic       dack_n_i,
	input  wire logic       tc_i,
	input  wire logic       nondma_select_i,
	input  wire logic       dma_enable_i,
	input  wire logic [1:0] mode_select_i,
	input  wire logic       fifo_enable_i,
	input  wire logic       burst_mode_i,
	input  wire logic [3:0] fifo_trigger_level_i,
	input  wire logic       disk_byte_i,
	input  wire logic       sector_end_i,
	input  wire logic       next_sector_i,
	input  wire logic       exec_done_i,
	output logic      [7:0] main_status_register_o,
	output logic            drq_o,
	output logic            floppy_interrupt_line_o,
	output logic      [1:0] phase_o,
	output logic      [4:0] fifo_count_o
);

	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam int SW = $clog2(SECTOR_BYTES + 1);
	localparam logic [3:0] GAP_CYC = 4'(`GAP_CYCLES);
	localparam int DROP_CYC = `DROP_CYCLES;

	typedef struct packed {
		phase_t        phase;
		dir_t          dir;
		logic          use_dma;
		logic [7:0]    opcode;
		logic [3:0]    params_left;
		logic [3:0]    results_left;
		logic          req;
		logic          more;
		logic [3:0]    gap;
		logic          end_irq;
		logic          sector_done;
		logic [SW-1:0] sector_cnt;
		logic          strobed;
		logic          prev_wr_n;
		logic          prev_rd_n;
		logic          prev_dack_n;
		logic [7:0]    main_status_register;
		logic          drq;
		logic          irq;
	} state_t;

	localparam state_t RESET_STATE = '{
		phase:        PH_IDLE,
		dir:          DIR_NONE,
		use_dma:      1'b0,
		opcode:       8'h00,
		params_left:  4'h0,
		results_left: 4'h0,
		req:          1'b0,
		more:         1'b0,
		gap:          4'h0,
		end_irq:      1'b0,
		sector_done:  1'b0,
		sector_cnt:   '0,
		strobed:      1'b0,
		prev_wr_n:    1'b1,
		prev_rd_n:    1'b1,
		prev_dack_n:  1'b1,
		main_status_register:          `MSR_RESET,
		drq:          1'b0,
		irq:          1'b0
	};

	//------------------------------------------------------------------
	// opcode decode
	//------------------------------------------------------------------
	function automatic logic [3:0] param_count(input logic [4:0] op);
		unique case (op)
			`OP_READ_DATA,
			`OP_WRITE_DATA:  param_count = `PAR_DATA;
			`OP_SPECIFY:     param_count = `PAR_SPECIFY;
			`OP_RECALIBRATE: param_count = `PAR_RECAL;
			`OP_SEEK:        param_count = `PAR_SEEK;
			default:         param_count = `PAR_NONE;
		endcase
	endfunction

	function automatic logic [3:0] result_count(input logic [4:0] op);
		unique case (op)
			`OP_READ_DATA,
			`OP_WRITE_DATA:  result_count = `RES_DATA;
			`OP_SENSE_INT:   result_count = `RES_SENSE;
			`OP_SPECIFY,
			`OP_RECALIBRATE,
			`OP_SEEK:        result_count = `RES_NONE;
			default:         result_count = `RES_INVALID;
		endcase
	endfunction

	function automatic dir_t cmd_dir(input logic [4:0] op);
		unique case (op)
			`OP_READ_DATA:  cmd_dir = DIR_READ;
			`OP_WRITE_DATA: cmd_dir = DIR_WRITE;
			default:        cmd_dir = DIR_NONE;
		endcase
	endfunction

	state_t        s;
	state_t        n;
	logic [CW-1:0] count;
	logic [CW-1:0] level;

	//------------------------------------------------------------------
	// pin events
	//------------------------------------------------------------------
	logic wr_fall;
	logic rd_fall;
	logic cpu_wr;
	logic cpu_rd;
	logic dack_fall;
	logic dack_rise;
	logic strobe_end;
	logic in_exec;
	logic data_cmd;
	logic is_read;
	logic dma_xfer;
	logic cpu_xfer;
	logic xfer;
	logic push;
	logic pop;
	logic use_dma_now;
	logic [3:0] eff_thr;
	logic per_byte;
	logic fifo_empty;
	logic fifo_full;
	logic sector_full;
	logic last_in_sector;
	logic final_byte;
	logic read_trig;
	logic write_trig;
	logic trigger;
	logic tc_hit;
	logic exec_end;
	logic drop;

	assign wr_fall    = s.prev_wr_n & ~host_wr_n_i;
	assign rd_fall    = s.prev_rd_n & ~host_rd_n_i;
	assign cpu_wr     = ~host_cs_n_i & host_data_sel_i & wr_fall;
	assign cpu_rd     = ~host_cs_n_i & host_data_sel_i & rd_fall;
	assign dack_fall  = s.prev_dack_n & ~dack_n_i;
	assign dack_rise  = ~s.prev_dack_n & dack_n_i;
	assign strobe_end = ~dack_n_i & ((~s.prev_rd_n & host_rd_n_i) | (~s.prev_wr_n & host_wr_n_i));
	assign in_exec    = s.phase == PH_EXECUTION;
	assign data_cmd   = in_exec & (s.dir != DIR_NONE);
	assign is_read    = s.dir == DIR_READ;

	// dack alone selects the FIFO; dack without a strobe still counts a byte
	assign dma_xfer = data_cmd & s.use_dma & (strobe_end | (dack_rise & ~s.strobed));
	assign cpu_xfer = data_cmd & ~s.use_dma & (is_read ? cpu_rd : cpu_wr);
	assign xfer     = dma_xfer | cpu_xfer;
	assign push     = data_cmd & (is_read ? disk_byte_i : xfer);
	assign pop      = data_cmd & (is_read ? xfer : disk_byte_i);

	// second compat mode ignores the drive register DMA enable
	assign use_dma_now = ~nondma_select_i & (dma_enable_i | (mode_select_i == `MODE_SECOND));

	//------------------------------------------------------------------
	// request conditions
	//------------------------------------------------------------------
	assign eff_thr        = fifo_enable_i ? fifo_trigger_level_i : `THR_FIFO_OFF;
	assign per_byte       = ~fifo_enable_i | ~burst_mode_i;
	assign fifo_empty     = count == '0;
	assign fifo_full      = int'(count) == FIFO_DEPTH;
	assign sector_full    = s.sector_cnt == SW'(SECTOR_BYTES);
	assign last_in_sector = (s.dir == DIR_WRITE) & (s.sector_cnt == SW'(SECTOR_BYTES - 1));
	assign final_byte     = is_read ? (int'(count) == 1)
	                              : ((int'(count) == FIFO_DEPTH - 1) | last_in_sector);
	// level after this cycle's push or pop, so a popped byte cannot retrigger
	assign level          = (push & ~pop & ~fifo_full) ? count + CW'(1)
	                      : (pop & ~push & ~fifo_empty) ? count - CW'(1) : count;
	assign read_trig      = (int'(level) >= FIFO_DEPTH - int'(eff_thr))
	                      | (s.sector_done & (level != '0));
	assign write_trig     = (int'(level) <= int'(eff_thr)) & ~sector_full
	                      & ~(xfer & last_in_sector);
	assign trigger        = is_read ? read_trig : write_trig;
	assign tc_hit         = in_exec & s.use_dma & tc_i & ~dack_n_i;
	assign exec_end       = in_exec & (tc_hit | (exec_done_i & (~is_read | fifo_empty)));

	// drop at dack leading edge or after the counted byte
	assign drop = ((dack_fall & s.use_dma) | xfer) & (per_byte | final_byte);

	always_comb begin
		n             = s;
		n.prev_wr_n   = host_wr_n_i;
		n.prev_rd_n   = host_rd_n_i;
		n.prev_dack_n = dack_n_i;
		n.strobed     = dack_n_i ? 1'b0 : (s.strobed | strobe_end);

		// sector byte count and end-of-sector flag
		if (data_cmd && s.dir == DIR_WRITE && xfer && !sector_full) begin
			n.sector_cnt = s.sector_cnt + SW'(1);
		end else if (next_sector_i || s.phase == PH_IDLE) begin
			n.sector_cnt = '0;
		end
		if (sector_end_i && data_cmd) begin
			n.sector_done = 1'b1;
		end else if (fifo_empty) begin
			n.sector_done = 1'b0;
		end

		//--------------------------------------------------------------
		// request level with gap timer
		//--------------------------------------------------------------
		if (!data_cmd) begin
			n.req = 1'b0;
			n.gap = 4'h0;
		end else if (s.req) begin
			if (drop) begin
				n.req  = 1'b0;
				n.more = ~final_byte;
				n.gap  = (fifo_enable_i && !burst_mode_i) ? GAP_CYC : 4'h0;
			end else if (!per_byte && (is_read ? fifo_empty : (fifo_full | sector_full))) begin
				n.req = 1'b0;
			end
		end else if (s.gap > 4'h1) begin
			n.gap = s.gap - 4'h1;
		end else if (s.gap == 4'h1) begin
			// gap over: carry on while data or room is left
			if (dack_n_i || !s.use_dma) begin
				n.gap = 4'h0;
				n.req = trigger | (s.more & (is_read ? (level != '0) : (int'(level) != FIFO_DEPTH)));
			end
		end else if (trigger && (dack_n_i || !s.use_dma)) begin
			n.req = 1'b1;
		end

		//--------------------------------------------------------------
		// phase sequencing
		//--------------------------------------------------------------
		unique case (s.phase)
			PH_IDLE: begin
				if (cpu_wr) begin
					n.opcode      = host_wdata_i;
					n.params_left = param_count(host_wdata_i[4:0]);
					n.dir         = cmd_dir(host_wdata_i[4:0]);
					n.use_dma     = use_dma_now;
					n.end_irq     = 1'b0;
					n.phase       = PH_COMMAND;
					if (param_count(host_wdata_i[4:0]) == 4'h0) begin
						n.phase = PH_EXECUTION;
					end
				end
			end
			PH_COMMAND: begin
				if (cpu_wr) begin
					n.params_left = s.params_left - 4'h1;
					if (s.params_left == 4'h1) begin
						n.phase = PH_EXECUTION;
						if (result_count(s.opcode[4:0]) == 4'h0) begin
							n.phase = PH_IDLE;
							n.dir   = DIR_NONE;
						end
					end
				end
			end
			PH_EXECUTION: begin
				if (exec_end) begin
					n.end_irq      = 1'b1;
					n.req          = 1'b0;
					n.gap          = 4'h0;
					n.results_left = result_count(s.opcode[4:0]);
					n.phase        = PH_RESULT;
					if (result_count(s.opcode[4:0]) == 4'h0) begin
						n.phase = PH_IDLE;
						n.dir   = DIR_NONE;
					end
				end
			end
			PH_RESULT: begin
				if (cpu_rd) begin
					n.end_irq      = 1'b0;
					n.results_left = s.results_left - 4'h1;
					if (s.results_left == 4'h1) begin
						n.phase = PH_IDLE;
						n.dir   = DIR_NONE;
					end
				end
			end
		endcase

		if (soft_reset_i) begin
			n = RESET_STATE;
		end

		//--------------------------------------------------------------
		// registered outputs
		//--------------------------------------------------------------
		n.main_status_register           = 8'h00;
		n.main_status_register[`MSR_RQM] = (n.phase != PH_EXECUTION) | (~n.use_dma & n.req);
		n.main_status_register[`MSR_DIO] = (n.phase == PH_RESULT)
		                | ((n.phase == PH_EXECUTION) & ~n.use_dma & n.req & (n.dir == DIR_READ));
		n.main_status_register[`MSR_NDMA] = (n.phase == PH_EXECUTION) & ~n.use_dma & (n.dir != DIR_NONE);
		n.main_status_register[`MSR_CIP] = n.phase != PH_IDLE;
		n.drq           = n.req & n.use_dma;
		n.irq           = n.end_irq | (n.req & ~n.use_dma);
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= RESET_STATE;
		end else begin
			s <= n;
		end
	end

	fifo_level_counter #(
		.DEPTH (FIFO_DEPTH),
		.CW    (CW)
	) u_level (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.clear_i  ((s.phase == PH_IDLE) | soft_reset_i),
		.push_i   (push),
		.pop_i    (pop),
		.count_o  (count)
	);

	assign main_status_register_o  = s.main_status_register;
	assign drq_o                   = s.drq;
	assign floppy_interrupt_line_o = s.irq;
	assign phase_o                 = s.phase;
	assign fifo_count_o            = 5'(count);

	//------------------------------------------------------------------
	// assertions
	//------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i || soft_reset_i);

	property p_idle_flags;
		(s.phase == PH_IDLE) |-> (s.main_status_register[`MSR_RQM] && !s.main_status_register[`MSR_DIO] && !s.main_status_register[`MSR_CIP]);
	endproperty
	a_idle_flags: assert property (p_idle_flags) else $error("idle flags wrong");

	property p_result_from_exec;
		($changed(s.phase) && s.phase == PH_RESULT) |-> $past(s.phase) == PH_EXECUTION;
	endproperty
	a_result_from_exec: assert property (p_result_from_exec) else $error("bad phase order");

	property p_busy_on_opcode;
		(s.phase == PH_IDLE && cpu_wr && result_count(host_wdata_i[4:0]) != 4'h0)
			|=> s.main_status_register[`MSR_CIP] ##1 s.main_status_register[`MSR_CIP];
	endproperty
	a_busy_on_opcode: assert property (p_busy_on_opcode) else $error("busy flag not set");

	property p_busy_clear;
		(s.phase == PH_RESULT && cpu_rd && s.results_left == 4'h1) |=> !main_status_register_o[`MSR_CIP];
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("busy flag not cleared");

	property p_exec_start;
		(s.phase == PH_COMMAND && cpu_wr && s.params_left == 4'h1
			&& result_count(s.opcode[4:0]) != 4'h0) |=> s.phase == PH_EXECUTION;
	endproperty
	a_exec_start: assert property (p_exec_start) else $error("execution not started");

	property p_dack_drop;
		(data_cmd && s.req && s.use_dma && !fifo_enable_i && dack_fall) |=> !drq_o;
	endproperty
	a_dack_drop: assert property (p_dack_drop) else $error("request not dropped on dack");

	property p_tc_gated;
		(in_exec && tc_i && dack_n_i && !exec_done_i) |=> s.phase == PH_EXECUTION;
	endproperty
	a_tc_gated: assert property (p_tc_gated) else $error("terminal count taken without dack");

	property p_end_irq;
		(in_exec && s.use_dma && exec_end && result_count(s.opcode[4:0]) != 4'h0)
			|=> (s.phase == PH_RESULT && floppy_interrupt_line_o);
	endproperty
	a_end_irq: assert property (p_end_irq) else $error("no end interrupt");

	property p_irq_clear;
		(s.phase == PH_RESULT && cpu_rd && s.end_irq) |=> !floppy_interrupt_line_o;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("end interrupt not cleared");

	property p_gap;
		($fell(drq_o) && s.phase == PH_EXECUTION && fifo_enable_i && !burst_mode_i)
			|-> !drq_o [*8];
	endproperty
	a_gap: assert property (p_gap) else $error("request gap too short");

	property p_read_trigger;
		(data_cmd && is_read && s.use_dma && !s.req && s.gap == 4'h0 && dack_n_i
			&& fifo_enable_i && read_trig && !exec_end) |=> drq_o;
	endproperty
	a_read_trigger: assert property (p_read_trigger) else $error("read request missing");

	property p_sector_drop;
		(xfer && last_in_sector && s.req) |=> !drq_o && !s.req;
	endproperty
	a_sector_drop: assert property (p_sector_drop) else $error("no drop at sector end");

	property p_nondma_irq;
		(in_exec && !s.use_dma && s.req) |-> floppy_interrupt_line_o && !drq_o;
	endproperty
	a_nondma_irq: assert property (p_nondma_irq) else $error("byte interrupt missing");

	property p_strobe_drop;
		(data_cmd && s.req && s.use_dma && !per_byte && strobe_end && final_byte)
			|-> ##[1:DROP_CYC] !drq_o;
	endproperty
	a_strobe_drop: assert property (p_strobe_drop) else $error("late burst drop");

	c_result_done: cover property (s.phase == PH_RESULT && cpu_rd && s.results_left == 4'h1);
	c_tc_end: cover property (tc_hit);
	c_dack_taken: cover property (dack_fall && drq_o);
	c_burst_full: cover property (in_exec && fifo_full && burst_mode_i);

endmodule
